// ==== pce_accumulator.sv ====
/*
  Measurement sequencer and arithmetic back end: steps the converter through
  current, offset, supply and auxiliary inputs, stores results, forms power,
  integrates charge and energy, runs snapshot conversions and drives the alert
  pin. Assumes an external 12-bit converter on the same clock that answers a
  start with one done pulse, and an AXI4-Lite master on aclk.
*/
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "pce_consts.svh"

module pce_accumulator (
  input wire logic aclk,                            // System clock, 100 MHz
  input wire logic aresetn,                         // Synchronous reset, low
  input wire logic [7:0] s_axi_awaddr,              // Write address
  input wire logic s_axi_awvalid,                   // Write address valid
  output logic s_axi_awready,                       // Write address ready
  input wire logic [31:0] s_axi_wdata,              // Write data
  input wire logic [3:0] s_axi_wstrb,               // Write byte strobes
  input wire logic s_axi_wvalid,                    // Write data valid
  output logic s_axi_wready,                        // Write data ready
  output logic [1:0] s_axi_bresp,                   // Write response
  output logic s_axi_bvalid,                        // Write response valid
  input wire logic s_axi_bready,                    // Write response ready
  input wire logic [7:0] s_axi_araddr,              // Read address
  input wire logic s_axi_arvalid,                   // Read address valid
  output logic s_axi_arready,                       // Read address ready
  output logic [31:0] s_axi_rdata,                  // Read data
  output logic [1:0] s_axi_rresp,                   // Read response
  output logic s_axi_rvalid,                        // Read data valid
  input wire logic s_axi_rready,                    // Read data ready
  output pce_pkg::pce_conv_req_t conv_req,          // Converter request
  input wire pce_pkg::pce_conv_rsp_t conv_rsp,      // Converter result
  input wire logic general_pin_two_i,               // Pin two level
  output logic general_pin_three_o,                 // Pin three drive level
  output logic general_pin_three_oe                 // Pin three drive enable
);
  import pce_pkg::*;

  pce_state_t s_r;
  pce_state_t s_nxt;
  logic [9:0] div_top;
  logic wr_go;
  logic rd_go;
  logic ctrl_wr;
  logic done;
  logic cur_done;
  logic acc_step;
  logic [11:0] cur_use;
  logic [23:0] pwr_use;
  logic [31:0] time_base;
  logic [35:0] chg_base;
  logic [47:0] nrg_base;
  logic [32:0] time_sum;
  logic [36:0] chg_sum;
  logic [48:0] nrg_sum;
  pce_chan_t pick;
  logic [1:0] kind;

  // Mapped register test, shared by read and write paths
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a[1:0] == 2'h0) && (a <= `PCE_OFF_ENERGY);
  endfunction : reg_hit

  // Byte-strobe merge of a write onto the old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction : merge

  // Supply channel chosen by the source field
  function automatic pce_chan_t volt_chan(input logic [1:0] src);
    unique case (src)
      `PCE_SRC_VDD: volt_chan = CH_VDD;
      `PCE_SRC_AUX: volt_chan = CH_AUX;
      default: volt_chan = CH_SENSE_HI;
    endcase
  endfunction : volt_chan

  // Snapshot channel code
  function automatic pce_chan_t snap_chan(input logic [1:0] code);
    unique case (code)
      2'h0: snap_chan = CH_CURRENT;
      2'h1: snap_chan = CH_VDD;
      2'h2: snap_chan = CH_SENSE_HI;
      default: snap_chan = CH_AUX;
    endcase
  endfunction : snap_chan

  // Slot pattern per duty code: 0 current, 1 supply, 2 auxiliary
  function automatic logic [1:0] duty_kind(input logic [2:0] duty, input logic [1:0] slot);
    logic [7:0] pat;
    unique case (duty)
      3'h0: pat = 8'h44;
      3'h1: pat = 8'h24;
      3'h2: pat = 8'h88;
      3'h3: pat = 8'h04;
      3'h4: pat = 8'h08;
      3'h5: pat = 8'h09;
      default: pat = 8'h00;
    endcase
    duty_kind = pat[2*slot +: 2];
  endfunction : duty_kind

  // Calibration due for the current rate setting
  function automatic logic cal_due(input logic [1:0] rate, input logic [6:0] since);
    unique case (rate)
      `PCE_CAL_EVERY: cal_due = since >= 7'd1;
      `PCE_CAL_16: cal_due = since >= `PCE_CONV_CAL_16;
      `PCE_CAL_64: cal_due = since >= `PCE_CONV_CAL_64;
      default: cal_due = 1'b0;
    endcase
  endfunction : cal_due

  // Next state of the whole block
  always_comb begin
    s_nxt = s_r;
    s_nxt.conv_req.start = 1'b0;
    s_nxt.conv_req.sample_en = 1'b0;
    pick = CH_CURRENT;
    kind = 2'h0;
    // Pin two synchroniser
    s_nxt.gp2_meta = general_pin_two_i;
    s_nxt.gp2_sync = s_r.gp2_meta;
    // Sample clock divider, period four times the setting
    div_top = {((s_r.clkdiv == 8'h00) ? 8'h01 : s_r.clkdiv), 2'b00} - 10'h001;
    if (s_r.div_cnt >= div_top) begin
      s_nxt.div_cnt = 10'h000;
      s_nxt.conv_req.sample_en = 1'b1; // RULE24
    end else begin
      s_nxt.div_cnt = s_r.div_cnt + 10'h001;
    end
    // Write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    wr_go = s_r.aw_have && s_r.w_have && !s_r.bvalid;
    ctrl_wr = wr_go && (s_r.aw_addr == `PCE_OFF_CTRL) && s_r.wstrb[0];
    if (wr_go) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = reg_hit(s_r.aw_addr) ? 2'b00 : 2'b10;
      unique case (s_r.aw_addr)
        `PCE_OFF_ALERT: s_nxt.alert_en = 8'(merge({24'h0, s_r.alert_en}, s_r.wdata, s_r.wstrb));
        `PCE_OFF_GPIO: s_nxt.gpio_cfg = 2'(merge({30'h0, s_r.gpio_cfg}, s_r.wdata, s_r.wstrb));
        `PCE_OFF_CLKDIV: s_nxt.clkdiv = 8'(merge({24'h0, s_r.clkdiv}, s_r.wdata, s_r.wstrb));
        `PCE_OFF_FAULT: s_nxt.flags = s_r.flags & ~(s_r.wdata[3:0] & {4{s_r.wstrb[0]}});
        default: s_nxt.bresp = s_nxt.bresp;
      endcase
    end
    // Converter result capture
    done = (s_r.seq == SQ_CONV) && conv_rsp.done;
    cur_done = done && (s_r.conv_req.chan == CH_CURRENT) && !s_r.conv_snap;
    if (done) begin
      unique case (s_r.conv_req.chan)
        CH_CURRENT: s_nxt.cur = conv_rsp.data; // RULE1 RULE14
        CH_VDD, CH_SENSE_HI: s_nxt.volt = conv_rsp.data; // RULE2 RULE14
        CH_AUX: begin
          s_nxt.aux = conv_rsp.data; // RULE3 RULE14
          if (!s_r.conv_snap && (s_r.ctrl[`PCE_CA_SRC_HI:`PCE_CA_SRC_LO] == `PCE_SRC_AUX)) begin
            s_nxt.volt = conv_rsp.data; // RULE4
          end
        end
        default: s_nxt.since_cal = 7'd0;
      endcase
      if (s_r.conv_req.chan != CH_OFFSET && s_r.since_cal != 7'h7f) begin
        s_nxt.since_cal = s_r.since_cal + 7'd1;
      end
      if (s_r.conv_snap) begin
        s_nxt.busy = 1'b0; // RULE20
        s_nxt.flags[`PCE_FL_SNAP] = 1'b1; // RULE21
        s_nxt.seq = SQ_HALT;
      end else begin
        s_nxt.seq = SQ_IDLE;
      end
    end
    // Power from new current and previous voltage
    if (cur_done) begin
      s_nxt.power = 24'(conv_rsp.data) * 24'(s_r.volt); // RULE5
    end
    // Channel choice for the next conversion
    if (s_r.seq == SQ_IDLE) begin
      if (s_r.ctrl[`PCE_CA_DUTY_HI:`PCE_CA_DUTY_LO] == `PCE_DUTY_SNAP) begin
        if (s_r.busy) begin
          s_nxt.conv_req.start = 1'b1;
          s_nxt.conv_req.chan = snap_chan(s_r.ctrl[`PCE_CA_SRC_HI:`PCE_CA_SRC_LO]); // RULE19
          s_nxt.conv_snap = 1'b1;
          s_nxt.seq = SQ_CONV;
        end
      end else begin
        if (s_r.need_cal || cal_due(s_r.ctrl[`PCE_CA_CAL_HI:`PCE_CA_CAL_LO], s_r.since_cal)) begin
          pick = CH_OFFSET; // RULE7 RULE8
          s_nxt.need_cal = 1'b0;
        end else if (s_r.need_volt) begin
          pick = volt_chan(s_r.ctrl[`PCE_CA_SRC_HI:`PCE_CA_SRC_LO]); // RULE10
          s_nxt.need_volt = 1'b0;
        end else begin
          kind = duty_kind(s_r.ctrl[`PCE_CA_DUTY_HI:`PCE_CA_DUTY_LO], s_r.slot); // RULE6 RULE9
          pick = (kind == 2'h1) ? volt_chan(s_r.ctrl[`PCE_CA_SRC_HI:`PCE_CA_SRC_LO]) :
                 (kind == 2'h2) ? CH_AUX : CH_CURRENT;
          s_nxt.slot = s_r.slot + 2'h1;
        end
        s_nxt.conv_req.start = 1'b1;
        s_nxt.conv_req.chan = pick;
        s_nxt.conv_snap = 1'b0;
        s_nxt.seq = SQ_CONV;
      end
    end
    // Control write restarts the sequence; wins over same-cycle events
    if (ctrl_wr) begin
      s_nxt.ctrl = s_r.wdata[7:0];
      s_nxt.need_cal = 1'b1; // RULE7 RULE10
      s_nxt.need_volt = 1'b1;
      s_nxt.slot = 2'h0;
      if (s_r.wdata[`PCE_CA_DUTY_HI:`PCE_CA_DUTY_LO] == `PCE_DUTY_SNAP) begin
        s_nxt.busy = 1'b1; // RULE19 RULE20
      end
      if (s_nxt.seq == SQ_HALT) begin
        s_nxt.seq = SQ_IDLE;
      end
    end
    // Accumulation step on every continuous conversion, gated by pin two
    acc_step = done && !s_r.conv_snap && (!s_r.gpio_cfg[`PCE_GP_ACC] || s_r.gp2_sync); // RULE12 RULE22
    cur_use = cur_done ? conv_rsp.data : s_r.cur;
    pwr_use = cur_done ? s_nxt.power : s_r.power;
    // Preload merges with the step in the same cycle
    time_base = s_r.timer;
    chg_base = s_r.charge;
    nrg_base = s_r.energy;
    if (wr_go && s_r.aw_addr == `PCE_OFF_TIME) begin
      time_base = merge(s_r.timer, s_r.wdata, s_r.wstrb); // RULE18 RULE25
    end
    if (wr_go && s_r.aw_addr == `PCE_OFF_CHARGE) begin
      chg_base = {merge(s_r.charge[35:4], s_r.wdata, s_r.wstrb), 4'h0}; // RULE16 RULE25
    end
    if (wr_go && s_r.aw_addr == `PCE_OFF_ENERGY) begin
      nrg_base = {merge(s_r.energy[47:16], s_r.wdata, s_r.wstrb), 16'h0000}; // RULE16 RULE25
    end
    time_sum = {1'b0, time_base} + {32'h0, acc_step}; // RULE11 RULE15
    chg_sum = {1'b0, chg_base} + (acc_step ? 37'(cur_use) : 37'h0); // RULE11
    nrg_sum = {1'b0, nrg_base} + (acc_step ? 49'(pwr_use) : 49'h0); // RULE11
    s_nxt.timer = time_sum[31:0];
    s_nxt.charge = chg_sum[35:0];
    s_nxt.energy = nrg_sum[47:0];
    // Overflow flags; a set beats a same-cycle clear
    if (time_sum[32]) s_nxt.flags[`PCE_FL_TIME] = 1'b1; // RULE18
    if (chg_sum[36]) s_nxt.flags[`PCE_FL_CHARGE] = 1'b1; // RULE18
    if (nrg_sum[48]) s_nxt.flags[`PCE_FL_ENERGY] = 1'b1; // RULE18
    // Register read; time read freezes charge and energy copies
    rd_go = s_axi_arvalid && s_axi_arready;
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = reg_hit(s_axi_araddr) ? 2'b00 : 2'b10;
      unique case (s_axi_araddr)
        `PCE_OFF_CTRL: s_nxt.rdata = {24'h0, s_r.ctrl};
        `PCE_OFF_ALERT: s_nxt.rdata = {24'h0, s_r.alert_en};
        `PCE_OFF_STATUS: s_nxt.rdata = {28'h0, s_r.busy, 3'h0};
        `PCE_OFF_FAULT: s_nxt.rdata = {28'h0, s_r.flags};
        `PCE_OFF_GPIO: s_nxt.rdata = {30'h0, s_r.gpio_cfg};
        `PCE_OFF_CLKDIV: s_nxt.rdata = {24'h0, s_r.clkdiv};
        `PCE_OFF_CUR_MSB: s_nxt.rdata = {24'h0, s_r.cur[11:4]}; // RULE13
        `PCE_OFF_CUR_LSB: s_nxt.rdata = {24'h0, s_r.cur[3:0], 4'h0}; // RULE13
        `PCE_OFF_VIN_MSB: s_nxt.rdata = {24'h0, s_r.volt[11:4]};
        `PCE_OFF_VIN_LSB: s_nxt.rdata = {24'h0, s_r.volt[3:0], 4'h0};
        `PCE_OFF_AUX_MSB: s_nxt.rdata = {24'h0, s_r.aux[11:4]};
        `PCE_OFF_AUX_LSB: s_nxt.rdata = {24'h0, s_r.aux[3:0], 4'h0};
        `PCE_OFF_POWER: s_nxt.rdata = {8'h0, s_r.power};
        `PCE_OFF_TIME: begin
          s_nxt.rdata = s_r.timer;
          s_nxt.shd_charge = s_r.charge[35:4]; // RULE17
          s_nxt.shd_energy = s_r.energy[47:16]; // RULE17
        end
        `PCE_OFF_CHARGE: s_nxt.rdata = s_r.shd_charge; // RULE16 RULE17
        `PCE_OFF_ENERGY: s_nxt.rdata = s_r.shd_energy;
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    // Alert level from enabled sticky conditions
    s_nxt.alert = |(s_r.flags & {s_r.alert_en[`PCE_AL_SNAP], s_r.alert_en[2:0]}); // RULE21 RULE18
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.ctrl <= `PCE_CTRL_RST;
      s_r.alert_en <= `PCE_ALERT_RST;
      s_r.gpio_cfg <= `PCE_GPIO_RST;
      s_r.clkdiv <= `PCE_CLKDIV_RST;
      s_r.seq <= SQ_IDLE;
      s_r.conv_req.chan <= CH_OFFSET;
      s_r.need_cal <= 1'b1;
      s_r.need_volt <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign s_axi_awready = !s_r.aw_have && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_have && !s_r.bvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign conv_req = s_r.conv_req;
  assign general_pin_three_o = 1'b0;
  assign general_pin_three_oe = s_r.alert && s_r.gpio_cfg[`PCE_GP_ALERT]; // RULE23

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_snap_write;
    ctrl_wr && (s_r.wdata[2:0] == 3'h7);
  endsequence
  sequence s_snap_done;
    done && s_r.conv_snap;
  endsequence

  property p_busy_set;
    s_snap_write |=> s_r.busy;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set by snapshot write"); // RULE20

  property p_snap_end;
    (s_snap_done and !ctrl_wr) |=> !s_r.busy && s_r.flags[3] && (s_r.seq == SQ_HALT);
  endproperty
  a_snap_end: assert property (p_snap_end) else $error("snapshot end not recorded"); // RULE20

  property p_snap_freeze;
    s_r.conv_snap && (s_r.seq == SQ_CONV) && !wr_go |=> $stable(s_r.timer) && $stable(s_r.power);
  endproperty
  a_snap_freeze: assert property (p_snap_freeze) else $error("accumulators moved in snapshot"); // RULE22

  property p_time_inc;
    acc_step && !wr_go |=> s_r.timer == $past(s_r.timer) + 32'h1;
  endproperty
  a_time_inc: assert property (p_time_inc) else $error("time counter not advanced"); // RULE11

  property p_charge_add;
    cur_done && acc_step && !wr_go |=> s_r.charge == $past(s_r.charge) + 36'($past(conv_rsp.data));
  endproperty
  a_charge_add: assert property (p_charge_add) else $error("charge not accumulated"); // RULE11

  property p_power;
    cur_done |=> s_r.power == 24'($past(conv_rsp.data)) * 24'($past(s_r.volt));
  endproperty
  a_power: assert property (p_power) else $error("power product wrong"); // RULE5

  property p_cal_first;
    ctrl_wr && (s_r.wdata[2:0] != 3'h7) ##1 (s_r.seq == SQ_IDLE) [*1] |=> s_r.conv_req.chan == CH_OFFSET;
  endproperty
  a_cal_first: assert property (p_cal_first) else $error("offset not first after control write"); // RULE7

  property p_volt_next;
    (s_r.seq == SQ_IDLE) && !s_r.need_cal && s_r.need_volt && (s_r.ctrl[2:0] != 3'h7)
      && !cal_due(s_r.ctrl[6:5], s_r.since_cal) |=> s_r.conv_req.chan == volt_chan(s_r.ctrl[4:3]);
  endproperty
  a_volt_next: assert property (p_volt_next) else $error("supply not converted after offset"); // RULE10

  property p_lsb_zero;
    rd_go && (s_axi_araddr == 8'h1c) |=> (s_r.rdata[3:0] == 4'h0) && (s_r.rdata[7:4] == $past(s_r.cur[3:0]));
  endproperty
  a_lsb_zero: assert property (p_lsb_zero) else $error("low result register misformatted"); // RULE13

  property p_alert_pin;
    s_r.alert && s_r.gpio_cfg[0] |-> general_pin_three_oe && !general_pin_three_o;
  endproperty
  a_alert_pin: assert property (p_alert_pin) else $error("alert pin not pulled low"); // RULE23

endmodule : pce_accumulator

// ==== pce_consts.svh ====
// Contract
// RULE1: Current sense code is 12 bits, 102.4mV.
// RULE2: Supply voltage code is 12 bits, 102.4V.
// RULE3: Auxiliary input code is 12 bits, 2.048V.
// RULE4: Supply source select picks voltage; sense-high default.
// RULE5: Power is current code times voltage code.
// RULE6: Channel mix follows calibration rate and duty.
// RULE7: Offset first after reset/control write; rate 00.
// RULE8: Rate 01 calibrates every 16 conversions.
// RULE9: Duty 110 converts current continuously.
// RULE10: Control write forces offset then voltage conversion.
// RULE11: Current done: time, charge, energy advance.
// RULE12: Other slots accumulate last current and power.
// RULE13: Result split: eight high, four low, zeros.
// RULE14: Data registers update right after conversion.
// RULE15: Four-byte elapsed time counter of accumulations.
// RULE16: Charge 36, energy 48 bits; upper 32 visible.
// RULE17: Accumulator page read sees one coherent snapshot.
// RULE18: Preloadable accumulators, overflow can raise alert.
// RULE19: Snapshot start: one byte write, duty 111.
// RULE20: Snapshot busy set on write, cleared when stored.
// RULE21: Enabled snapshot-done raises an alert.
// RULE22: Snapshot mode freezes power, time and accumulators.
// RULE23: Pin three as alert drives low on alert.
// RULE24: Sample clock is input clock over four times divider.
// RULE25: Preload writes merge atomically with accumulation steps.
/*
  Register offsets, field positions, reset values and timing counts of the
  power, charge and energy accumulator. Assumes a byte-addressed AXI4-Lite
  bus with 8 address bits and one 32-bit word per register.
*/
`ifndef PCE_CONSTS_SVH
`define PCE_CONSTS_SVH

// Register byte offsets
`define PCE_OFF_CTRL 8'h00
`define PCE_OFF_ALERT 8'h04
`define PCE_OFF_STATUS 8'h08
`define PCE_OFF_FAULT 8'h0c
`define PCE_OFF_GPIO 8'h10
`define PCE_OFF_CLKDIV 8'h14
`define PCE_OFF_CUR_MSB 8'h18
`define PCE_OFF_CUR_LSB 8'h1c
`define PCE_OFF_VIN_MSB 8'h20
`define PCE_OFF_VIN_LSB 8'h24
`define PCE_OFF_AUX_MSB 8'h28
`define PCE_OFF_AUX_LSB 8'h2c
`define PCE_OFF_POWER 8'h30
`define PCE_OFF_TIME 8'h34
`define PCE_OFF_CHARGE 8'h38
`define PCE_OFF_ENERGY 8'h3c

// Control field positions
`define PCE_CA_DUTY_HI 2
`define PCE_CA_DUTY_LO 0
`define PCE_CA_SRC_HI 4
`define PCE_CA_SRC_LO 3
`define PCE_CA_CAL_HI 6
`define PCE_CA_CAL_LO 5
`define PCE_DUTY_CONT_I 3'h6
`define PCE_DUTY_SNAP 3'h7
`define PCE_SRC_VDD 2'h0
`define PCE_SRC_SENSE 2'h1
`define PCE_SRC_AUX 2'h2
`define PCE_CAL_EVERY 2'h0
`define PCE_CAL_16 2'h1
`define PCE_CAL_64 2'h2

// Status, fault, alert and gpio bits
`define PCE_ST_BUSY 3
`define PCE_FL_TIME 0
`define PCE_FL_CHARGE 1
`define PCE_FL_ENERGY 2
`define PCE_FL_SNAP 3
`define PCE_AL_SNAP 7
`define PCE_GP_ALERT 0
`define PCE_GP_ACC 1

// Reset values
`define PCE_CTRL_RST 8'h08
`define PCE_ALERT_RST 8'h00
`define PCE_GPIO_RST 2'h0

// Timing
`define PCE_CLK_HZ 100000000
`define PCE_SAMPLE_HZ 250000
`define PCE_CLKDIV_RST 8'((`PCE_CLK_HZ) / (4 * (`PCE_SAMPLE_HZ)))
`define PCE_CONV_CAL_16 7'd16
`define PCE_CONV_CAL_64 7'd64

`endif

// ==== pce_conv_model.sv ====
/*
  Converter stand-in: answers each start with one done pulse dly+1 cycles after the edge that samples it.
  Assumes requests come from the accumulator on the same clock.
*/
`timescale 1ns/10ps

module pce_conv_model (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, low
  input wire pce_pkg::pce_conv_req_t conv_req, // Request
  input wire logic [7:0] dly, // Answer delay
  output pce_pkg::pce_conv_rsp_t conv_rsp // Result
);
  import pce_pkg::*;
  logic [7:0] cnt_r;
  logic busy_r;
  pce_chan_t ch_r;

  // Fixed code per input channel
  function automatic logic [11:0] code(input pce_chan_t c);
    case (c)
      CH_CURRENT: code = 12'habc;
      CH_VDD: code = 12'h111;
      CH_SENSE_HI: code = 12'h234;
      CH_AUX: code = 12'h345;
      default: code = 12'h005;
    endcase
  endfunction : code

  // One done per start; data toggles outside the done cycle
  always_ff @(posedge aclk) begin
    conv_rsp.done <= 1'b0;
    conv_rsp.data <= ~conv_rsp.data;
    if (!aresetn) begin
      busy_r <= 1'b0;
      conv_rsp.data <= 12'h000;
    end else if (conv_req.start) begin
      busy_r <= 1'b1;
      cnt_r <= dly;
      ch_r <= conv_req.chan;
    end else if (busy_r && cnt_r == 8'h00) begin
      busy_r <= 1'b0;
      conv_rsp.done <= 1'b1;
      conv_rsp.data <= code(ch_r);
    end else begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule : pce_conv_model

// ==== pce_pkg.sv ====
/*
  Types of the power, charge and energy accumulator: converter request and
  result carriers, sequencer states and the whole-module state record.
  Assumes the constants header is included by the modules that use it.
*/
package pce_pkg;

  // Converter input selection
  typedef enum logic [2:0] {CH_CURRENT, CH_OFFSET, CH_VDD, CH_SENSE_HI, CH_AUX} pce_chan_t;

  // Sequencer states
  typedef enum logic [1:0] {SQ_IDLE, SQ_CONV, SQ_HALT} pce_seq_t;

  // Request to the converter
  typedef struct packed {
    logic sample_en;
    logic start;
    pce_chan_t chan;
  } pce_conv_req_t;

  // Result from the converter
  typedef struct packed {
    logic done;
    logic [11:0] data;
  } pce_conv_rsp_t;

  // All state of the accumulator module
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] alert_en;
    logic [1:0] gpio_cfg;
    logic [7:0] clkdiv;
    logic [3:0] flags;
    logic [11:0] cur;
    logic [11:0] volt;
    logic [11:0] aux;
    logic [23:0] power;
    logic [31:0] timer;
    logic [35:0] charge;
    logic [47:0] energy;
    logic [31:0] shd_charge;
    logic [31:0] shd_energy;
    logic [9:0] div_cnt;
    pce_conv_req_t conv_req;
    pce_seq_t seq;
    logic conv_snap;
    logic busy;
    logic need_cal;
    logic need_volt;
    logic [6:0] since_cal;
    logic [1:0] slot;
    logic alert;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic gp2_meta;
    logic gp2_sync;
  } pce_state_t;

endpackage : pce_pkg

// ==== power_charge_energy_accumulator_bench.sv ====
/*
  Bench of the accumulator: AXI4-Lite register tasks and directed tests.
  Assumes the converter stand-in on the far side.
*/
`timescale 1ns/10ps
`include "pce_consts.svh"

module power_charge_energy_accumulator_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, gp2, p3_o, p3_oe;
  logic [7:0] s_axi_awaddr, s_axi_araddr, dly;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  int k;
  logic [11:0] vexp [4] = '{12'h111, 12'h234, 12'h345, 12'h234};
  pce_pkg::pce_conv_req_t conv_req;
  pce_pkg::pce_conv_rsp_t conv_rsp;
  int num_errors = 0;
  int n_checks = 0;

  pce_accumulator i_pce_accumulator (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .conv_req, .conv_rsp, .general_pin_two_i(gp2), .general_pin_three_o(p3_o),
    .general_pin_three_oe(p3_oe));
  pce_conv_model i_pce_conv_model (.aclk, .aresetn, .conv_req, .dly, .conv_rsp);

  // Clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // Register write; readies sampled before each edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, b;
    ta = 1'b0;
    tw = 1'b0;
    b = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta | (s_axi_awvalid & s_axi_awready);
      tw = tw | (s_axi_wvalid & s_axi_wready);
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    while (!b) begin
      @(negedge aclk);
      b = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
    end
  endtask : wr

  // Register read into rd and rr
  task automatic rdr(input logic [7:0] a);
    logic t;
    t = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!t) begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end
    s_axi_arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge aclk);
      t = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
    end
  endtask : rdr

  // Test sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, gp2} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    dly = 8'd20;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(`PCE_OFF_CTRL);
    chk("ctrl", 32'h08, rd);
    rdr(`PCE_OFF_CLKDIV);
    chk("clkdiv", 32'h64, rd);
    // One sample enable per four times the divider setting
    @(posedge aclk iff conv_req.sample_en);
    k = 0;
    repeat (400) begin
      @(posedge aclk);
      k += conv_req.sample_en;
    end
    chk("sample_rate", 32'd1, k);
    rdr(`PCE_OFF_CUR_MSB);
    chk("cur_msb", 32'hab, rd);
    rdr(`PCE_OFF_CUR_LSB);
    chk("cur_lsb", 32'hc0, rd);
    rdr(`PCE_OFF_POWER);
    chk("power", 32'h17a630, rd);
    rdr(8'hfc);
    chk("rresp", 32'h2, {30'h0, rr});
    wr(8'hfc, 32'h0);
    chk("bresp", 32'h2, {30'h0, br});
    // Every supply source, with restart of offset and supply
    for (int s = 0; s < 4; s++) begin
      wr(`PCE_OFF_CTRL, 32'h66 + 32'(s * 8));
      repeat (300) @(posedge aclk);
      rdr(`PCE_OFF_VIN_MSB);
      chk("vin_msb", {24'h0, vexp[s][11:4]}, rd);
      rdr(`PCE_OFF_VIN_LSB);
      chk("vin_lsb", {24'h0, vexp[s][3:0], 4'h0}, rd);
    end
    wr(`PCE_OFF_TIME, 32'h0);
    chk("bresp_ok", 32'h0, {30'h0, br});
    repeat (100) @(posedge aclk);
    rdr(`PCE_OFF_TIME);
    chk("time_run", 32'h1, {31'h0, rd != 32'h0});
    // Slow snapshot of the aux input with done alert
    wr(`PCE_OFF_ALERT, 32'h80);
    wr(`PCE_OFF_GPIO, 32'h1);
    wr(`PCE_OFF_CTRL, 32'h1f);
    dly <= 8'd60;
    rdr(`PCE_OFF_STATUS);
    chk("busy", 32'h8, rd & 32'h8);
    // Let the last continuous conversion finish before preloading
    repeat (30) @(posedge aclk);
    wr(`PCE_OFF_TIME, 32'h100);
    wr(`PCE_OFF_CHARGE, 32'h1234);
    repeat (200) @(posedge aclk);
    rdr(`PCE_OFF_STATUS);
    chk("busy_end", 32'h0, rd & 32'h8);
    chk("alert_oe", 32'h1, {31'h0, p3_oe});
    chk("alert_o", 32'h0, {31'h0, p3_o});
    rdr(`PCE_OFF_AUX_MSB);
    chk("aux_msb", 32'h34, rd);
    rdr(`PCE_OFF_AUX_LSB);
    chk("aux_lsb", 32'h50, rd);
    rdr(`PCE_OFF_TIME);
    chk("time_hold", 32'h100, rd);
    rdr(`PCE_OFF_CHARGE);
    chk("charge", 32'h1234, rd);
    tally_and_finish();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    tally_and_finish();
  end
endmodule : power_charge_energy_accumulator_bench
